//--- design/gpcw_top.sv
// gpio port configuration, wake sources and port c request register
`timescale 1ns/10ps
`default_nettype none
module gpcw_top
    import gpcw_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [31:0] pins_i,
    input wire logic stop_mode_i,
    input wire logic global_irq_en_i,
    output logic [31:0] high_drive_o,
    output logic [31:0] alt_func_en_o,
    output logic [GPCW_ANALOG_PINS-1:0] analog_input_channel_o,
    output logic vref_sel_o,
    output logic external_clock_input_o,
    output logic wake_o,
    output logic irq_o,
    output logic [3:0] port_c_pin_irq_pending_o
);
    logic [GPCW_PORTS-1:0][7:0] port_ptr;
    logic [GPCW_PORTS-1:0][7:0] alt_func_enable;
    logic [GPCW_PORTS-1:0][7:0] pin_high_current_select;
    logic [GPCW_PORTS-1:0][7:0] pin_wake_source_select;
    logic [GPCW_PORTS-1:0][7:0] alt_func_select_one;
    logic [GPCW_PORTS-1:0][7:0] alt_func_select_two;
    logic [GPCW_PORTS-1:0][7:0] port_rd_data;
    logic [GPCW_PORTS-1:0] port_rd_hit;
    logic [3:0] port_c_pin_irq_pending;
    logic [31:0] pins_last;
    logic [31:0] high_flat;
    logic [31:0] wake_flat;
    logic [31:0] af_en_flat;
    logic [GPCW_PC_REQS-1:0] port_c_pin_request_bit;
    logic [3:0] next_pending;
    logic [7:0] next_rdata;
    logic irq_wr;
    logic irq_rd;
    logic pin_edge_any;
    logic next_wake;
    logic [7:0] port_b_sel;
    logic [7:0] port_b_en;

    genvar p;
    generate
        for (p = 0; p < GPCW_PORTS; p++) begin : g_port
            localparam logic [11:0] PTR_ADDR =
                12'(GPCW_PORT_PTR_BASE + 12'(p) * GPCW_PORT_STRIDE);
            localparam logic [11:0] CTL_ADDR =
                12'(PTR_ADDR + GPCW_PORT_CTL_OFS);
            localparam bit HAS_AFS = (p == GPCW_PORT_B) || (p == GPCW_PORT_C);
            wire ptr_hit = (reg_addr_i == PTR_ADDR);
            wire ctl_hit = (reg_addr_i == CTL_ADDR);
            wire ctl_wr = reg_wr_i && ctl_hit;
            wire af_en_wr = ctl_wr && (port_ptr[p] == GPCW_SUB_AF_EN);
            wire hde_wr = ctl_wr && (port_ptr[p] == GPCW_SUB_HIGH_DRIVE); // [R5]
            wire wake_wr = ctl_wr && (port_ptr[p] == GPCW_SUB_WAKE_SRC); // [R8]
            // set registers exist only on ports b and c [R3]
            wire alt_func_select_one_wr = HAS_AFS && ctl_wr &&
                (port_ptr[p] == GPCW_SUB_AFS_ONE);
            wire alt_func_select_two_wr = HAS_AFS && ctl_wr &&
                (port_ptr[p] == GPCW_SUB_AFS_TWO);
            wire [7:0] sub_data =
                (port_ptr[p] == GPCW_SUB_AF_EN) ? alt_func_enable[p] :
                (port_ptr[p] == GPCW_SUB_HIGH_DRIVE) ?
                    pin_high_current_select[p] :
                (port_ptr[p] == GPCW_SUB_WAKE_SRC) ?
                    pin_wake_source_select[p] :
                (port_ptr[p] == GPCW_SUB_AFS_ONE) ? alt_func_select_one[p] :
                (port_ptr[p] == GPCW_SUB_AFS_TWO) ? alt_func_select_two[p] :
                8'h00;

            assign port_rd_hit[p] = ptr_hit || ctl_hit;
            assign port_rd_data[p] = ptr_hit ? port_ptr[p] :
                (ctl_hit ? sub_data : 8'h00);
            assign high_flat[p*8 +: 8] = pin_high_current_select[p];
            assign wake_flat[p*8 +: 8] = pin_wake_source_select[p];
            assign af_en_flat[p*8 +: 8] = alt_func_enable[p];

            // reset to zero, read back in full [R11]
            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    port_ptr[p] <= GPCW_REG_RESET;
                    alt_func_enable[p] <= GPCW_REG_RESET;
                    pin_high_current_select[p] <= GPCW_REG_RESET;
                    pin_wake_source_select[p] <= GPCW_REG_RESET;
                    alt_func_select_one[p] <= GPCW_REG_RESET;
                    alt_func_select_two[p] <= GPCW_REG_RESET;
                end else begin
                    if (reg_wr_i && ptr_hit) begin
                        port_ptr[p] <= reg_wdata_i;
                    end
                    if (af_en_wr) begin
                        alt_func_enable[p] <= reg_wdata_i;
                    end
                    if (hde_wr) begin
                        pin_high_current_select[p] <= reg_wdata_i;
                    end
                    if (wake_wr) begin
                        pin_wake_source_select[p] <= reg_wdata_i;
                    end
                    if (alt_func_select_one_wr) begin
                        alt_func_select_one[p] <= reg_wdata_i;
                    end
                    if (alt_func_select_two_wr) begin
                        alt_func_select_two[p] <= reg_wdata_i;
                    end
                end
            end
        end
    endgenerate

    gpcw_edge_sync u_pc_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(pins_i[GPCW_PORT_C*8 +: GPCW_PC_REQS]),
        .rise_o(port_c_pin_request_bit)
    );

    assign irq_wr = reg_wr_i && (reg_addr_i == GPCW_IRQ_PEND_ADDR);
    assign irq_rd = reg_rd_i && (reg_addr_i == GPCW_IRQ_PEND_ADDR);
    // a request in the write cycle survives the write [R12] [R14]
    assign next_pending = (irq_wr ? reg_wdata_i[3:0] : port_c_pin_irq_pending)
        | port_c_pin_request_bit;

    // port b routing uses select-one only; select-two is only read back through the control register [R4]
    assign port_b_sel = alt_func_select_one[GPCW_PORT_B];
    assign port_b_en = alt_func_enable[GPCW_PORT_B];

    // wake path compares raw pins with their last sample [R16]
    assign pin_edge_any = |((pins_i ^ pins_last) & wake_flat);
    assign next_wake = stop_mode_i && pin_edge_any; // [R9] [R10]

    always_comb begin
        next_rdata = 8'h00;
        for (int i = 0; i < GPCW_PORTS; i++) begin
            if (port_rd_hit[i]) begin
                next_rdata = next_rdata | port_rd_data[i];
            end
        end
        // upper pending bits always read zero [R15]
        if (irq_rd) begin
            next_rdata = {4'h0, port_c_pin_irq_pending};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_c_pin_irq_pending <= GPCW_PEND_RESET;
            pins_last <= '0;
            wake_o <= 1'b0;
            irq_o <= 1'b0;
            reg_rdata_o <= 8'h00;
        end else begin
            port_c_pin_irq_pending <= next_pending;
            pins_last <= pins_i;
            wake_o <= next_wake;
            irq_o <= global_irq_en_i && (|next_pending); // [R13]
            if (reg_rd_i) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            high_drive_o <= '0;
            alt_func_en_o <= '0;
            analog_input_channel_o <= '0;
            vref_sel_o <= 1'b0;
            external_clock_input_o <= 1'b0;
            port_c_pin_irq_pending_o <= GPCW_PEND_RESET;
        end else begin
            // drive strength applies to the pad whatever feeds it [R6] [R7]
            high_drive_o <= high_flat;
            alt_func_en_o <= af_en_flat; // [R3]
            analog_input_channel_o <= port_b_sel[GPCW_ANALOG_PINS-1:0]
                & port_b_en[GPCW_ANALOG_PINS-1:0]; // [R1]
            vref_sel_o <= port_b_sel[GPCW_VREF_BIT]
                && port_b_en[GPCW_VREF_BIT]; // [R2]
            external_clock_input_o <= !port_b_sel[GPCW_EXTERNAL_CLOCK_INPUT_BIT]
                && port_b_en[GPCW_EXTERNAL_CLOCK_INPUT_BIT]; // [R1]
            port_c_pin_irq_pending_o <= next_pending;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    wire ctl_b_wr = reg_wr_i && (reg_addr_i == 12'(GPCW_PORT_PTR_BASE
        + GPCW_PORT_STRIDE + GPCW_PORT_CTL_OFS));

    a_hde_ptr_write: assert property ( // [R5]
        ctl_b_wr && port_ptr[GPCW_PORT_B] == GPCW_SUB_HIGH_DRIVE
        |=> ##1 high_drive_o[15:8] == $past(reg_wdata_i, 2))
        else $error("high drive write through pointer lost");
    a_wake_ptr_write: assert property ( // [R8]
        ctl_b_wr && port_ptr[GPCW_PORT_B] == GPCW_SUB_WAKE_SRC
        |=> pin_wake_source_select[GPCW_PORT_B] == $past(reg_wdata_i))
        else $error("wake source write through pointer lost");
    a_drive_follows_reg: assert property ( // [R6]
        $changed(high_flat)
        |=> high_drive_o == $past(high_flat))
        else $error("pad drive does not follow register");
    a_wake_on_edge: assert property ( // [R9]
        stop_mode_i && (|((pins_i ^ pins_last) & wake_flat)) |=> wake_o)
        else $error("enabled pin edge in stop gave no wake");
    a_no_masked_wake: assert property ( // [R10]
        !(stop_mode_i && (|((pins_i ^ pins_last) & wake_flat))) |=> !wake_o)
        else $error("wake without enabled pin edge");
    a_req_sets_bit: assert property ( // [R12]
        port_c_pin_request_bit[0] |=> port_c_pin_irq_pending_o[0])
        else $error("port c request did not set pending bit");
    a_irq_forward: assert property ( // [R13]
        global_irq_en_i && (|port_c_pin_irq_pending) && !irq_wr |=> irq_o)
        else $error("pending request not forwarded");
    a_poll_hold: assert property ( // [R14]
        !global_irq_en_i && port_c_pin_irq_pending[0] && !irq_wr
        |=> port_c_pin_irq_pending[0] && !irq_o)
        else $error("polled pending bit lost or forwarded");
    a_upper_zero: assert property ( // [R15]
        irq_rd |=> reg_rdata_o[7:4] == 4'h0)
        else $error("pending upper bits not zero");
    a_vref_route: assert property ( // [R2]
        port_b_sel[GPCW_VREF_BIT] && port_b_en[GPCW_VREF_BIT] |=> vref_sel_o)
        else $error("reference select not routed");
    a_alt_func_select_two_ignored: assert property ( // [R4]
        $stable(port_b_sel) && $stable(port_b_en) |=>
        $stable(analog_input_channel_o) && $stable(external_clock_input_o))
        else $error("routing moved without select-one change");

    c_wake: cover property (stop_mode_i ##1 wake_o);
    c_irq: cover property (port_c_pin_request_bit != 4'h0 ##1 irq_o);
    c_poll: cover property (!global_irq_en_i && irq_rd ##1
        reg_rdata_o != 8'h00);
    c_external_clock_input: cover property (external_clock_input_o);
endmodule
`default_nettype wire

//--- inc/gpcw_pkg.sv
// constants for the gpio port configuration and wake block
// Behaviour
// R1 - port b select-one bit 1 routes pin to analog input; bit3 at 0 gives clock input
// R2 - port b bit 5 at 1 selects reference voltage; pins 6 and 7 have none
// R3 - ports a and d pin 0 have no set registers; enable alone selects
// R4 - ports b and c keep select-two register but never use it for routing
// R5 - pointer 04h makes control register reach the high-drive subregister
// R6 - high-drive bit 0 gives standard current, 1 gives high current
// R7 - high-drive acts on the pin for port data and alternate functions alike
// R8 - pointer 05h makes control register reach the wake-source subregister
// R9 - in stop mode any edge on an enabled wake pin starts recovery
// R10 - in stop mode edges on a disabled wake pin start nothing
// R11 - high-drive and wake-source subregisters reset to zero, fully read/write
// R12 - a port c pin 0..3 request sets its pending bit 3..0; here pin 0..3 sets pending bit 0..3
// R13 - with interrupts globally enabled a pending request goes to the cpu
// R14 - with interrupts disabled pending bits stay set for software polling
// R15 - software writes zeros to pending bits 7..4; register resets to zero
// R16 - pin edges are synchronised before setting pending bits, not the wake path
package gpcw_pkg;
    localparam int GPCW_PORTS = 4;
    localparam int GPCW_PORT_A = 0;
    localparam int GPCW_PORT_B = 1;
    localparam int GPCW_PORT_C = 2;
    localparam int GPCW_PORT_D = 3;
    localparam int GPCW_PC_REQS = 4;
    localparam int GPCW_SYNC_STAGES = 2;
    localparam logic [11:0] GPCW_IRQ_PEND_ADDR = 12'hfc6;
    localparam logic [11:0] GPCW_PORT_PTR_BASE = 12'hfd0;
    localparam logic [11:0] GPCW_PORT_CTL_OFS = 12'h001;
    localparam logic [11:0] GPCW_PORT_STRIDE = 12'h004;
    localparam logic [7:0] GPCW_SUB_AF_EN = 8'h02;
    localparam logic [7:0] GPCW_SUB_HIGH_DRIVE = 8'h04;
    localparam logic [7:0] GPCW_SUB_WAKE_SRC = 8'h05;
    localparam logic [7:0] GPCW_SUB_AFS_ONE = 8'h07;
    localparam logic [7:0] GPCW_SUB_AFS_TWO = 8'h08;
    localparam logic [7:0] GPCW_REG_RESET = 8'h00;
    localparam logic [3:0] GPCW_PEND_RESET = 4'h0;
    localparam int GPCW_EXTERNAL_CLOCK_INPUT_BIT = 3;
    localparam int GPCW_VREF_BIT = 5;
    localparam int GPCW_ANALOG_PINS = 5;
endpackage

//--- design/gpcw_edge_sync.sv
// synchroniser and rising edge detector for the port c request pins
`timescale 1ns/10ps
`default_nettype none
module gpcw_edge_sync
    import gpcw_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [GPCW_PC_REQS-1:0] pin_i,
    output logic [GPCW_PC_REQS-1:0] rise_o
);
    logic [GPCW_PC_REQS-1:0] meta;
    logic [GPCW_PC_REQS-1:0] stable;
    logic [GPCW_PC_REQS-1:0] last;

    // two flops before any logic looks at the pin [R16]
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            stable <= '0;
            last <= '0;
        end else begin
            meta <= pin_i;
            stable <= meta;
            last <= stable;
        end
    end

    assign rise_o = stable & ~last;
endmodule
`default_nettype wire

//--- bench/gpcw_pin_model.sv
// pad-side model: plain pad levels and port c request pulses
`timescale 1ns/10ps
`default_nettype none
module gpcw_pin_model (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [31:0] level_i,
    input wire logic [3:0] pc_pulse_i,
    output logic [31:0] pins_o
);
    logic [3:0] pc_hi;
    // a request pin never stays high two samples running, so it is low between
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_hi <= 4'h0;
        end else begin
            pc_hi <= pc_pulse_i & ~pc_hi;
        end
    end
    assign pins_o = {level_i[31:20], pc_hi, level_i[15:0]};
endmodule
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the port configuration and wake block
`timescale 1ns/10ps
`default_nettype none
module tb
    import gpcw_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic stop_mode_i = 1'b0;
    logic global_irq_en_i = 1'b0;
    logic [31:0] level = 32'h0;
    logic [3:0] pc_pulse = 4'h0;
    logic [7:0] reg_rdata_o, v, h;
    logic [31:0] pins_i, high_drive_o, alt_func_en_o;
    logic [31:0] seed = 32'h29;
    logic [GPCW_ANALOG_PINS-1:0] analog_input_channel_o;
    logic vref_sel_o, external_clock_input_o, wake_o, irq_o, rd_q;
    logic [3:0] port_c_pin_irq_pending_o, x;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int n_checks = 0;
    int wakes;

    gpcw_pin_model pin_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .level_i(level), .pc_pulse_i(pc_pulse), .pins_o(pins_i));
    gpcw_top dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .pins_i(pins_i), .stop_mode_i(stop_mode_i),
        .global_irq_en_i(global_irq_en_i), .high_drive_o(high_drive_o),
        .alt_func_en_o(alt_func_en_o),
        .analog_input_channel_o(analog_input_channel_o),
        .vref_sel_o(vref_sel_o),
        .external_clock_input_o(external_clock_input_o), .wake_o(wake_o),
        .irq_o(irq_o), .port_c_pin_irq_pending_o(port_c_pin_irq_pending_o));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(negedge clk_sys_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        exp_q.push_back(e);
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
    endtask
    function automatic logic [11:0] pa(input int p);
        return GPCW_PORT_PTR_BASE + 12'(p) * GPCW_PORT_STRIDE;
    endfunction
    task automatic sub(input int p, input logic [7:0] s, input logic [7:0] d);
        wr(pa(p), s);
        wr(pa(p) + GPCW_PORT_CTL_OFS, d);
    endtask
    task automatic subrd(input int p, input logic [7:0] s,
                         input logic [7:0] e);
        wr(pa(p), s);
        rd(pa(p) + GPCW_PORT_CTL_OFS, e);
    endtask

    // read data settles one edge after the strobe is taken
    always @(posedge clk_sys_i) rd_q <= reg_rd_i;
    always @(negedge clk_sys_i) begin
        if (rd_q === 1'b1) begin
            if (exp_q.size() == 0) check("read queue", 32'h1, 32'h0);
            else check("reg_rdata_o", 32'(reg_rdata_o), 32'(exp_q.pop_front()));
        end
    end
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        results();
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        subrd(GPCW_PORT_C, GPCW_SUB_HIGH_DRIVE, GPCW_REG_RESET);
        subrd(GPCW_PORT_C, GPCW_SUB_WAKE_SRC, GPCW_REG_RESET);
        rd(GPCW_IRQ_PEND_ADDR, 8'h00);
        rd(12'h123, 8'h00);
        seed = xs(seed);
        h = seed[7:0];
        sub(GPCW_PORT_B, GPCW_SUB_AF_EN, 8'hff);
        sub(GPCW_PORT_B, GPCW_SUB_HIGH_DRIVE, h);
        subrd(GPCW_PORT_B, GPCW_SUB_HIGH_DRIVE, h);
        check("high_drive_o", high_drive_o, {16'h0, h, 8'h0});
        check("alt_func_en_o", alt_func_en_o, 32'h0000ff00);
        seed = xs(seed);
        v = seed[7:0];
        sub(GPCW_PORT_B, GPCW_SUB_AFS_ONE, v);
        sub(GPCW_PORT_B, GPCW_SUB_AFS_TWO, ~v);
        subrd(GPCW_PORT_B, GPCW_SUB_AFS_ONE, v);
        check("analog", 32'(analog_input_channel_o), 32'(v[4:0]));
        check("vref", 32'(vref_sel_o), 32'(v[5]));
        check("ext clock", 32'(external_clock_input_o), 32'(!v[3]));
        // all select-one bits low: pin 3 goes to the clock input
        sub(GPCW_PORT_B, GPCW_SUB_AFS_ONE, 8'h00);
        cycles(1);
        check("ext clock", 32'(external_clock_input_o), 32'h1);
        check("analog", 32'(analog_input_channel_o), 32'h0);
        check("vref", 32'(vref_sel_o), 32'h0);
        sub(GPCW_PORT_A, GPCW_SUB_AFS_ONE, 8'h55);
        subrd(GPCW_PORT_A, GPCW_SUB_AFS_ONE, 8'h00);
        sub(GPCW_PORT_A, GPCW_SUB_WAKE_SRC, 8'h01);
        subrd(GPCW_PORT_A, GPCW_SUB_WAKE_SRC, 8'h01);
        stop_mode_i = 1'b1;
        // pin 0 rises and falls, then the disabled pin 1 does the same
        for (int i = 0; i < 4; i++) begin
            wakes = 0;
            @(negedge clk_sys_i);
            level[i/2] = ~level[i/2];
            repeat (4) begin
                @(negedge clk_sys_i);
                if (wake_o === 1'b1) wakes++;
            end
            check("wake_o", 32'(wakes), (i < 2) ? 32'h1 : 32'h0);
        end
        stop_mode_i = 1'b0;
        seed = xs(seed);
        x = seed[3:0] | 4'h1;
        pc_pulse = x;
        cycles(1);
        pc_pulse = 4'h0;
        cycles(6);
        check("pending", 32'(port_c_pin_irq_pending_o), 32'(x));
        check("irq_o off", 32'(irq_o), 32'h0);
        rd(GPCW_IRQ_PEND_ADDR, {4'h0, x});
        global_irq_en_i = 1'b1;
        cycles(2);
        check("irq_o on", 32'(irq_o), 32'h1);
        wr(GPCW_IRQ_PEND_ADDR, 8'hf0);
        cycles(2);
        check("irq_o clear", 32'(irq_o), 32'h0);
        rd(GPCW_IRQ_PEND_ADDR, 8'h00);
        for (int i = 0; i < 10 && exp_q.size() > 0; i++) cycles(1);
        if (exp_q.size() > 0) n_errors++;
        results();
    end
endmodule
`default_nettype wire
